// >>> alm_ctrl_model.sv
// Bus controller model that loads the pointer and reads or writes registers.
`timescale 1ns/1ps
module alm_ctrl_model (
	input wire logic clk_sys, // System clock.
	output logic ptr_wr, // Pointer load strobe.
	output logic [7:0] ptr_byte, // Pointer byte.
	output logic reg_wr, // Register write strobe.
	output alm_pkg::alm_word_t reg_wdata, // Register write data.
	input wire alm_pkg::alm_word_t reg_rdata // Register read data.
);
	import alm_pkg::*;
	// Idle strobes at time zero.
	initial begin
		ptr_wr = 1'b0;
		ptr_byte = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 16'h0000;
	end
	// Loads the pointer, upper bits zero; idle byte is scrambled.
	task automatic set_ptr(input alm_ptr_t p);
		@(posedge clk_sys);
		ptr_wr <= 1'b1;
		ptr_byte <= {5'h00, p};
		@(posedge clk_sys);
		ptr_wr <= 1'b0;
		ptr_byte <= ~{5'h00, p};
	endtask
	// Writes one word; callers keep reserved bits zero.
	task automatic wr(input alm_ptr_t p, input alm_word_t d);
		set_ptr(p);
		reg_wr <= 1'b1;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	// Reads one word once the registered read data has settled.
	task automatic rd(input alm_ptr_t p, output alm_word_t d);
		set_ptr(p);
		repeat (3) @(posedge clk_sys);
		#1;
		d = reg_rdata;
	endtask
endmodule

// >>> alm_defines.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef ALM_DEFINES_SVH
`define ALM_DEFINES_SVH
`define ALM_PTR_RESULT 3'h0
`define ALM_PTR_STATUS 3'h1
`define ALM_PTR_CONFIG 3'h2
`define ALM_PTR_LOWER 3'h3
`define ALM_PTR_UPPER 3'h4
`define ALM_CFG_CYC_HI 7
`define ALM_CFG_CYC_LO 5
`define ALM_CFG_HOLD 4
`define ALM_CFG_SUMEN 3
`define ALM_CFG_PINEN 2
`define ALM_CFG_RSVD 1
`define ALM_CFG_POL 0
`define ALM_LIM_HI 11
`define ALM_LIM_LO 2
`define ALM_STS_OVER 1
`define ALM_STS_UNDER 0
`define ALM_RES_SUM 15
`define ALM_RST_CONFIG 8'h00
`define ALM_RST_LOWER 16'h0000
`define ALM_RST_UPPER 16'h0FFF
`define ALM_RST_PTR 3'h0
`define ALM_CYC_SHIFT_BASE 5'h04
`define ALM_T_CONV_NS 1000
`define ALM_CLK_NS 25
`define ALM_CONV_CYC ((`ALM_T_CONV_NS + `ALM_CLK_NS - 1) / `ALM_CLK_NS)
`endif

// >>> alm_limit_monitor.sv
// Configuration, threshold and limit-check logic of the converter monitor.
//
// Contract
// RQ1: Interval code zero disables auto conversion; resets zero.
// RQ2: Non-zero interval code starts automatic conversions.
// RQ3: Interval is conversion time times 32..2048.
// RQ4: Without hold, flags self-clear past the margin.
// RQ5: With hold, flags stay until written one.
// RQ6: Summary enable gates result bit 15.
// RQ7: Pin enable low floats interrupt output.
// RQ8: Polarity bit picks interrupt active level.
// RQ9: Reserved bits read zero; controller writes zeros.
// RQ10: Result below lower threshold sets under flag.
// RQ11: Result above upper threshold sets over flag.
// RQ12: Pointers 2,3,4 select config, lower, upper.
// RQ13: Reset values: upper 0FFFh, lower 0, config 0.
// RQ14: Violations set status flags; writing one clears.
// RQ15: First write byte loads pointer, low three bits.
// RQ16: Interrupt asserts when enabled and flag set.
// RQ17: Compare once per completed conversion result.
`timescale 1ns/1ps
`include "alm_defines.svh"

module alm_limit_monitor #(
	parameter int CONV_CYCLES = `ALM_CONV_CYC // Cycles per conversion.
) (
	input wire logic clk_sys, // System clock, 40 MHz.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic ptr_wr, // Pulse: pointer byte from the bus engine.
	input wire logic [7:0] ptr_byte, // First data byte of a bus write.
	input wire logic reg_wr, // Pulse: write to the selected register.
	input wire alm_pkg::alm_word_t reg_wdata, // Data for the register write.
	output alm_pkg::alm_word_t reg_rdata, // Selected register contents.
	input wire logic conv_done, // Pulse: a conversion has completed.
	input wire alm_pkg::alm_sample_t conv_data, // Result of that conversion.
	input wire alm_pkg::alm_sample_t threshold_margin, // Hysteresis value.
	output logic conv_start, // Pulse: start an automatic conversion.
	output logic alert_out, // Interrupt pin level when driven.
	output logic alert_oe_n // Low while the interrupt pin is driven.
);
	import alm_pkg::*;

	alm_ptr_t ptr_r; // Register pointer.
	alm_cfg_t cfg_r; // Configuration register.
	alm_sample_t lower_r; // Lower threshold field.
	alm_sample_t upper_r; // Upper threshold field.
	alm_sample_t result_r; // Latest conversion result.
	logic over_r; // Over-range violation flag.
	logic under_r; // Under-range violation flag.
	logic [23:0] cnt_r; // Interval down-counter.
	logic [23:0] cnt_nxt; // Next interval count.
	logic start_nxt; // Next start pulse.
	alm_word_t rdata_nxt; // Next read data.

	// Register selects decoded from the pointer.
	wire sel_sts = (ptr_r == `ALM_PTR_STATUS);
	wire sel_cfg = (ptr_r == `ALM_PTR_CONFIG); // RQ12
	wire sel_low = (ptr_r == `ALM_PTR_LOWER);
	wire sel_upp = (ptr_r == `ALM_PTR_UPPER);
	wire wr_sts = reg_wr & sel_sts;
	wire wr_cfg = reg_wr & sel_cfg;
	wire wr_low = reg_wr & sel_low;
	wire wr_upp = reg_wr & sel_upp;

	// Configuration fields.
	wire [2:0] cyc = cfg_r[`ALM_CFG_CYC_HI:`ALM_CFG_CYC_LO];
	wire auto_en = (cyc != 3'h0); // RQ1
	wire hold = cfg_r[`ALM_CFG_HOLD];
	wire sum_en = cfg_r[`ALM_CFG_SUMEN];
	wire pin_en = cfg_r[`ALM_CFG_PINEN];
	wire pol = cfg_r[`ALM_CFG_POL];

	// Interval is the conversion time shifted left by code plus four.
	wire [4:0] cyc_sh = {2'h0, cyc} + `ALM_CYC_SHIFT_BASE; // RQ3
	wire [23:0] conv24 = 24'(CONV_CYCLES);
	wire [23:0] interval = conv24 << cyc_sh; // RQ3

	// Limit comparisons on the new sample, with an 11-bit margin sum.
	wire over_hit = conv_data > upper_r; // RQ11
	wire under_hit = conv_data < lower_r; // RQ10
	wire [10:0] data_pm = {1'b0, conv_data} + {1'b0, threshold_margin};
	wire [10:0] low_pm = {1'b0, lower_r} + {1'b0, threshold_margin};
	wire over_back = data_pm < {1'b0, upper_r}; // RQ4
	wire under_back = {1'b0, conv_data} > low_pm; // RQ4

	// Flag updates: a violation beats any clear in the same cycle.
	wire over_clr = (wr_sts & reg_wdata[`ALM_STS_OVER]) |
		(conv_done & ~hold & over_back); // RQ14
	wire under_clr = (wr_sts & reg_wdata[`ALM_STS_UNDER]) |
		(conv_done & ~hold & under_back); // RQ14
	wire over_set = conv_done & over_hit; // RQ17
	wire under_set = conv_done & under_hit; // RQ17
	wire over_nxt = over_set | (over_r & ~over_clr); // RQ5
	wire under_nxt = under_set | (under_r & ~under_clr); // RQ5

	// Summary bit and interrupt level.
	wire any_flag = over_r | under_r;
	wire sum_bit = sum_en & any_flag; // RQ6
	wire alert_nxt = pol ? any_flag : ~any_flag; // RQ8 RQ16

	// Interval timer: fires at once when enabled, then every interval.
	always_comb begin
		cnt_nxt = cnt_r;
		start_nxt = 1'b0;
		if (!auto_en) begin
			cnt_nxt = 24'h000000; // RQ1
		end else if (cnt_r == 24'h000000) begin
			start_nxt = 1'b1; // RQ2
			cnt_nxt = interval - 24'h000001; // RQ3
		end else begin
			cnt_nxt = cnt_r - 24'h000001;
		end
	end

	// Read multiplexer; reserved bits are zero.
	always_comb begin
		case (ptr_r)
			`ALM_PTR_RESULT: rdata_nxt = {sum_bit, 3'h0, result_r, 2'h0};
			`ALM_PTR_STATUS: rdata_nxt = {14'h0000, over_r, under_r};
			`ALM_PTR_CONFIG: rdata_nxt = {8'h00, cfg_r}; // RQ9
			`ALM_PTR_LOWER: rdata_nxt = {4'h0, lower_r, 2'h0}; // RQ9
			`ALM_PTR_UPPER: rdata_nxt = {4'h0, upper_r, 2'h0}; // RQ9
			default: rdata_nxt = 16'h0000;
		endcase
	end

	// Pointer register loads the low three bits of the first byte.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ptr_r <= `ALM_RST_PTR;
		end else if (ptr_wr) begin
			ptr_r <= ptr_byte[2:0]; // RQ15
		end
	end

	// Configuration register; the reserved bit is held at zero.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg_r <= `ALM_RST_CONFIG; // RQ13
		end else if (wr_cfg) begin
			cfg_r <= reg_wdata[7:0] & ~(8'h01 << `ALM_CFG_RSVD); // RQ9
		end
	end

	// Threshold registers keep only their ten-bit fields.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lower_r <= 10'(`ALM_RST_LOWER >> `ALM_LIM_LO); // RQ13
			upper_r <= 10'(`ALM_RST_UPPER >> `ALM_LIM_LO); // RQ13
		end else begin
			if (wr_low) begin
				lower_r <= reg_wdata[`ALM_LIM_HI:`ALM_LIM_LO];
			end
			if (wr_upp) begin
				upper_r <= reg_wdata[`ALM_LIM_HI:`ALM_LIM_LO];
			end
		end
	end

	// Result capture, flags and timer.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			result_r <= 10'h000;
			over_r <= 1'b0;
			under_r <= 1'b0;
			cnt_r <= 24'h000000;
		end else begin
			if (conv_done) begin
				result_r <= conv_data;
			end
			over_r <= over_nxt; // RQ11 RQ4 RQ5
			under_r <= under_nxt; // RQ10 RQ4 RQ5
			cnt_r <= cnt_nxt;
		end
	end

	// Output flip-flops; reset loads the pin level low with enable high.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
			conv_start <= 1'b0;
			alert_out <= 1'b0;
			alert_oe_n <= 1'b1;
		end else begin
			reg_rdata <= rdata_nxt;
			conv_start <= start_nxt;
			alert_out <= alert_nxt; // RQ8
			alert_oe_n <= ~pin_en; // RQ7
		end
	end

	// Helper: cycles since last start, and whether the period is settled.
	logic [23:0] gap_r; // Cycles since the previous start pulse.
	logic seen_r; // A start has occurred since the last config write.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			gap_r <= 24'h000000;
			seen_r <= 1'b0;
		end else begin
			gap_r <= conv_start ? 24'h000001 : gap_r + 24'h000001;
			seen_r <= wr_cfg ? 1'b0 : (seen_r | conv_start);
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	AST_CYC_OFF: assert property (!auto_en |=> !conv_start) // RQ1
		else $error("Start pulse while interval code is zero.");
	AST_AUTO_START: assert property ($rose(auto_en) |=> conv_start) // RQ2
		else $error("Auto conversion did not start.");
	AST_INTERVAL: assert property ( // RQ3
		(conv_start && seen_r && !$past(wr_cfg)) |-> gap_r == interval)
		else $error("Conversion interval wrong.");
	AST_SELF_CLR: assert property ( // RQ4
		(!hold && conv_done && over_back && !over_hit) |=> !over_r)
		else $error("Over flag did not self-clear.");
	AST_HOLD: assert property ((hold && over_r && !wr_sts) |=> over_r) // RQ5
		else $error("Held over flag cleared by itself.");
	// The under flag must also survive a return inside the limit.
	AST_HOLD_UNDER: assert property ( // RQ5
		(hold && under_r && !wr_sts) |=> under_r)
		else $error("Held under flag cleared by itself.");
	AST_SUMMARY: assert property ( // RQ6
		(ptr_r == `ALM_PTR_RESULT && !sum_en)
		|=> !reg_rdata[`ALM_RES_SUM])
		else $error("Summary bit set while disabled.");
	AST_PIN_OFF: assert property (!pin_en |=> alert_oe_n) // RQ7
		else $error("Interrupt pin driven while disabled.");
	AST_ALERT_HI: assert property ( // RQ16
		(pin_en && pol && any_flag) |=> (alert_out && !alert_oe_n))
		else $error("Active-high interrupt not asserted.");
	AST_ALERT_LO: assert property ((!pol && any_flag) |=> !alert_out) // RQ8
		else $error("Active-low interrupt not asserted.");
	AST_RSVD: assert property (cfg_r[`ALM_CFG_RSVD] == 1'b0) // RQ9
		else $error("Reserved config bit set.");
	AST_UNDER_SET: assert property ( // RQ10
		(conv_done && under_hit) |=> under_r)
		else $error("Under flag not set.");
	AST_OVER_SET: assert property ((conv_done && over_hit) |=> over_r) // RQ11
		else $error("Over flag not set.");
	AST_W1C: assert property ( // RQ14
		(wr_sts && reg_wdata[`ALM_STS_UNDER] && !under_set) |=> !under_r)
		else $error("Under flag not cleared by write.");
	AST_PTR: assert property ( // RQ15
		ptr_wr |=> ptr_r == $past(ptr_byte[2:0]))
		else $error("Pointer not loaded.");
endmodule

// >>> alm_pkg.sv
// Types shared by the limit monitor register block.
package alm_pkg;
	typedef logic [2:0] alm_ptr_t;
	typedef logic [15:0] alm_word_t;
	typedef logic [9:0] alm_sample_t;
	typedef logic [7:0] alm_cfg_t;
endpackage

// >>> test_adc_limit_monitor_config.sv
// Self-checking testbench for the limit monitor register block.
`timescale 1ns/1ps
module test_adc_limit_monitor_config;
	import alm_pkg::*;
	logic clk_sys = 1'b0; // Clock.
	logic rst = 1'b1; // Reset.
	logic conv_done = 1'b0; // Conversion strobe.
	alm_sample_t conv_data = 10'h000; // Conversion result.
	alm_sample_t margin = 10'h004; // Hysteresis value.
	logic ptr_wr, reg_wr, conv_start, alert_out, alert_oe_n; // Wires.
	logic [7:0] ptr_byte; // Pointer byte.
	alm_word_t reg_wdata, reg_rdata, rd_v; // Bus words.
	int fail_count = 0; // Mismatches.
	int n_tests = 0; // Comparisons.
	int k; // Cycle count.
	always #12.5 clk_sys = ~clk_sys;
	alm_limit_monitor #(.CONV_CYCLES(2)) dut (.clk_sys(clk_sys), .rst(rst),
		.ptr_wr(ptr_wr), .ptr_byte(ptr_byte), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.conv_done(conv_done), .conv_data(conv_data),
		.threshold_margin(margin), .conv_start(conv_start),
		.alert_out(alert_out), .alert_oe_n(alert_oe_n));
	alm_ctrl_model ctl (.clk_sys(clk_sys), .ptr_wr(ptr_wr),
		.ptr_byte(ptr_byte), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata));
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test;
		$display("comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Compares a word.
	task automatic chk16(input alm_word_t got, input alm_word_t exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	// Compares a pin level at once, with no wait of its own.
	task automatic chk1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: pin %b, want %b", $time, got, exp);
		end
	endtask
	// Reads a register and compares it.
	task automatic rdchk(input alm_ptr_t p, input alm_word_t e);
		ctl.rd(p, rd_v);
		chk16(rd_v, e);
	endtask
	// Delivers one conversion result and lets the pin settle.
	task automatic conv(input alm_sample_t d);
		@(posedge clk_sys);
		conv_done <= 1'b1;
		conv_data <= d;
		@(posedge clk_sys);
		conv_done <= 1'b0;
		conv_data <= ~d;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	// Counts cycles up to the next start pulse; a hang ends the run.
	task automatic wait_start(output int n);
		n = 0;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (conv_start !== 1'b1 && n < 5000);
		if (n >= 5000) begin
			fail_count++;
			$display("mismatch at %0t: no start pulse", $time);
			stop_test();
		end
	endtask
	// Reset values, unmapped pointer and write-back of the lower threshold and config registers.
	task automatic t_regs;
		rdchk(3'h2, 16'h0000);
		rdchk(3'h3, 16'h0000);
		rdchk(3'h4, 16'h0FFC);
		rdchk(3'h5, 16'h0000);
		chk1(alert_oe_n, 1'b1);
		ctl.wr(3'h3, 16'h0A5C);
		rdchk(3'h3, 16'h0A5C);
		ctl.wr(3'h2, 16'h001D);
		rdchk(3'h2, 16'h001D);
	endtask
	// Over range, summary bit, self-clear past the margin, pin control.
	task automatic t_over;
		ctl.wr(3'h3, 16'h0000);
		ctl.wr(3'h4, 16'h0100);
		ctl.wr(3'h2, 16'h000D);
		conv(10'h040);
		chk1(alert_out, 1'b0);
		conv(10'h041);
		chk1(alert_out, 1'b1);
		chk1(alert_oe_n, 1'b0);
		rdchk(3'h1, 16'h0002);
		rdchk(3'h0, 16'h8104);
		conv(10'h03C);
		rdchk(3'h1, 16'h0002);
		conv(10'h03B);
		rdchk(3'h1, 16'h0000);
		ctl.wr(3'h2, 16'h0004);
		conv(10'h041);
		rdchk(3'h0, 16'h0104);
		chk1(alert_out, 1'b0);
		ctl.wr(3'h2, 16'h0000);
		rdchk(3'h1, 16'h0002);
		chk1(alert_oe_n, 1'b1);
		ctl.wr(3'h1, 16'h0002);
		rdchk(3'h1, 16'h0000);
	endtask
	// Under range with hold: no self-clear, write one clears.
	task automatic t_hold;
		ctl.wr(3'h3, 16'h0080);
		ctl.wr(3'h2, 16'h0015);
		conv(10'h020);
		rdchk(3'h1, 16'h0000);
		conv(10'h01F);
		rdchk(3'h1, 16'h0001);
		conv(10'h030);
		rdchk(3'h1, 16'h0001);
		ctl.wr(3'h1, 16'h0001);
		rdchk(3'h1, 16'h0000);
		chk1(alert_out, 1'b0);
	endtask
	// Every interval code, then code zero stops the pulses.
	task automatic t_timer;
		for (int c = 1; c < 8; c++) begin
			ctl.wr(3'h2, {8'h00, 3'(c), 5'h00});
			wait_start(k);
			wait_start(k);
			chk16(16'(k), 16'(2 << (c + 4)));
			ctl.wr(3'h2, 16'h0000);
		end
		k = 0;
		repeat (300) begin
			@(posedge clk_sys);
			#1;
			if (conv_start !== 1'b0) k++;
		end
		chk16(16'(k), 16'h0000);
	endtask
	// Main sequence.
	initial begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		t_regs();
		t_over();
		t_hold();
		t_timer();
		stop_test();
	end
endmodule
